// ---- verilog/torque_cutoff_supervisor.sv ----
// Top of the dual-channel safe_torque_disable supervisor.
// Assumes synchronous command inputs; channel pins are asynchronous contacts.
`timescale 1ns/100ps
module torque_cutoff_supervisor #(
  parameter int unsigned FILT_CYC  = torque_cutoff_pkg::FILT_CYC,
  parameter int unsigned DISC_CYC  = torque_cutoff_pkg::DISC_CYC,
  parameter logic [15:0] DUAL_CODE = torque_cutoff_pkg::CODE_DUAL_DEF
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rstn,
  input  wire logic                         chan_a_in,
  input  wire logic                         chan_b_in,
  input  wire logic                         start_cmd,
  input  wire logic                         reset_cmd,
  input  wire torque_cutoff_pkg::ind_cfg_s  ind_cfg,
  output logic                              gate_enable_q,
  output logic                              running_q,
  output logic [15:0]                       fault_code_q,
  output torque_cutoff_pkg::ind_s           ind_q
);

  localparam int DW = $clog2(DISC_CYC + 1);

  logic                          chan_a;
  logic                          chan_b;
  logic                          both_closed;
  logic                          cut_evt;
  logic                          closed_prev_q;
  logic [DW-1:0]                 disc_cnt_q;
  logic [DW-1:0]                 disc_cnt_d;
  logic                          disc_hit;
  logic                          fa81_q;
  logic                          fa81_d;
  logic                          fa82_q;
  logic                          fa82_d;
  logic                          cfg_fault_q;
  logic                          cfg_fault_d;
  logic                          armed_q;
  logic                          armed_d;
  logic                          any_fault;
  torque_cutoff_pkg::ind_sel_e   sel;
  torque_cutoff_pkg::sup_state_e state_q;
  torque_cutoff_pkg::sup_state_e state_d;
  torque_cutoff_pkg::ind_s       ind_d;
  logic [15:0]                   code_d;

  // ----------------------------------------------------------------
  // Channel inputs
  // ----------------------------------------------------------------
  channel_filter #(.FILT_CYC(FILT_CYC)) u_filt_a (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .chan_in (chan_a_in),
    .chan_q  (chan_a)
  );

  channel_filter #(.FILT_CYC(FILT_CYC)) u_filt_b (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .chan_in (chan_b_in),
    .chan_q  (chan_b)
  );

  // Cut event fires when the pair leaves the both-closed condition
  assign both_closed = chan_a && chan_b;
  assign cut_evt     = closed_prev_q && !both_closed;
  assign any_fault   = fa81_q || fa82_q || cfg_fault_q;
  assign disc_hit    = (chan_a != chan_b) && (disc_cnt_q == DW'(DISC_CYC));
  assign sel         = (state_q == torque_cutoff_pkg::ST_RUN) ? ind_cfg.run_sel
                                                               : ind_cfg.stop_sel;

  // ----------------------------------------------------------------
  // Channel discrepancy and fault flags
  // ----------------------------------------------------------------
  // Discrepancy timer allows the partner's skew, then latches the fault
  always_comb begin
    disc_cnt_d  = '0;
    fa81_d      = fa81_q;
    fa82_d      = fa82_q;
    cfg_fault_d = cfg_fault_q;
    if (chan_a != chan_b && !disc_hit) begin
      disc_cnt_d = disc_cnt_q + DW'(1);
    end else if (disc_hit) begin
      disc_cnt_d = disc_cnt_q;
    end
    // Single fault clears only with both channels open
    if (reset_cmd && !chan_a && !chan_b) begin
      fa81_d = 1'b0;
      fa82_d = 1'b0;
    end
    // Configured fault clears on reset once the channels are restored
    if (reset_cmd && both_closed) begin
      cfg_fault_d = 1'b0;
    end
    // Setting wins over a same-cycle reset
    if (disc_hit && !chan_a) begin
      fa81_d = 1'b1;
    end
    if (disc_hit && !chan_b) begin
      fa82_d = 1'b1;
    end
    if (cut_evt && sel == torque_cutoff_pkg::IND_FAULT) begin
      cfg_fault_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      disc_cnt_q    <= '0;
      fa81_q        <= 1'b0;
      fa82_q        <= 1'b0;
      cfg_fault_q   <= 1'b0;
      closed_prev_q <= 1'b0;
    end else begin
      disc_cnt_q    <= disc_cnt_d;
      fa81_q        <= fa81_d;
      fa82_q        <= fa82_d;
      cfg_fault_q   <= cfg_fault_d;
      closed_prev_q <= both_closed;
    end
  end

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  // Start needs restored channels, no faults and a start seen low first
  always_comb begin
    state_d = state_q;
    armed_d = armed_q;
    if (!start_cmd) begin
      armed_d = 1'b1;
    end
    unique case (state_q)
      torque_cutoff_pkg::ST_IDLE: begin
        if (!both_closed) begin
          state_d = torque_cutoff_pkg::ST_CUT;
        end else if (start_cmd && armed_q && !any_fault) begin
          state_d = torque_cutoff_pkg::ST_RUN;
        end
      end
      torque_cutoff_pkg::ST_RUN: begin
        if (!both_closed) begin
          state_d = torque_cutoff_pkg::ST_CUT;
        end else if (!start_cmd || any_fault) begin
          state_d = torque_cutoff_pkg::ST_IDLE;
        end
      end
      torque_cutoff_pkg::ST_CUT: begin
        if (both_closed) begin
          state_d = torque_cutoff_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = torque_cutoff_pkg::ST_CUT;
      end
    endcase
    // A start held through a cut or a pending fault never counts as fresh
    if (state_d == torque_cutoff_pkg::ST_CUT || any_fault) begin
      armed_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= torque_cutoff_pkg::ST_CUT;
      armed_q <= 1'b0;
    end else begin
      state_q <= state_d;
      armed_q <= armed_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Fault indication and fault code follow the next flag values
  always_comb begin
    ind_d.event_p = cut_evt && (sel == torque_cutoff_pkg::IND_EVENT);
    ind_d.warning = (ind_q.warning && !both_closed)
                    || (cut_evt && (sel == torque_cutoff_pkg::IND_WARN));
    ind_d.fault   = fa81_d || fa82_d || cfg_fault_d;
    if (fa81_d) begin
      code_d = torque_cutoff_pkg::CODE_CHAN_A;
    end else if (fa82_d) begin
      code_d = torque_cutoff_pkg::CODE_CHAN_B;
    end else if (cfg_fault_d) begin
      code_d = DUAL_CODE;
    end else begin
      code_d = torque_cutoff_pkg::CODE_NONE;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gate_enable_q <= 1'b0;
      running_q     <= 1'b0;
      fault_code_q  <= torque_cutoff_pkg::CODE_NONE;
      ind_q         <= '0;
    end else begin
      gate_enable_q <= (state_d == torque_cutoff_pkg::ST_RUN) && both_closed;
      running_q     <= (state_d == torque_cutoff_pkg::ST_RUN);
      fault_code_q  <= code_d;
      ind_q         <= ind_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_cutoff;
    @(posedge sys_clk) disable iff (!rstn)
      !both_closed |=> !gate_enable_q;
  endproperty
  a_cutoff: assert property (p_cutoff)
    else $error("gate enable held with a channel open");

  property p_single_fault;
    @(posedge sys_clk) disable iff (!rstn)
      ((chan_a != chan_b) && (disc_cnt_q == DW'(DISC_CYC))) |=> (fa81_q || fa82_q);
  endproperty
  a_single_fault: assert property (p_single_fault)
    else $error("single channel loss raised no fault");

  property p_code_a;
    @(posedge sys_clk) disable iff (!rstn)
      fa81_q |-> (fault_code_q == torque_cutoff_pkg::CODE_CHAN_A);
  endproperty
  a_code_a: assert property (p_code_a)
    else $error("first channel fault code wrong");

  property p_run_stops;
    @(posedge sys_clk) disable iff (!rstn)
      (state_q == torque_cutoff_pkg::ST_RUN && !both_closed)
        |=> (state_q == torque_cutoff_pkg::ST_CUT) ##1 !running_q;
  endproperty
  a_run_stops: assert property (p_run_stops)
    else $error("running drive did not stop on channel loss");

  property p_no_fault_start;
    @(posedge sys_clk) disable iff (!rstn)
      gate_enable_q |-> (!fa81_q && !fa82_q && !cfg_fault_q && $past(both_closed));
  endproperty
  a_no_fault_start: assert property (p_no_fault_start)
    else $error("output stage enabled with fault or open channel");

  property p_start_ignored;
    @(posedge sys_clk) disable iff (!rstn)
      (!both_closed && start_cmd) |=> (state_q != torque_cutoff_pkg::ST_RUN);
  endproperty
  a_start_ignored: assert property (p_start_ignored)
    else $error("start accepted with a channel open");

  property p_cfg_reset;
    @(posedge sys_clk) disable iff (!rstn)
      (cfg_fault_q && !reset_cmd) |=> cfg_fault_q;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("configured fault cleared without reset");

  property p_fresh_start;
    @(posedge sys_clk) disable iff (!rstn)
      $rose(running_q) |-> $past(armed_q);
  endproperty
  a_fresh_start: assert property (p_fresh_start)
    else $error("start from a stale start request");

  property p_single_clear;
    @(posedge sys_clk) disable iff (!rstn)
      (fa81_q && reset_cmd && !chan_a && !chan_b) |=> !fa81_q;
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("single fault not cleared by reset with both open");

endmodule // torque_cutoff_supervisor

// ---- verilog/torque_cutoff_pkg.sv ----
// Constants, types and state codes shared by the torque cutoff supervisor files.
// Assumes a single 25 MHz control clock and an active-low asynchronous reset.
// Behaviour
// - Either channel open removes switch gate enable
// - Ignore channel pulses up to 1 ms
// - Single channel loss always raises a fault
// - Code FA81 first channel, FA82 second
// - Configuration selects indication on channel loss
// - Separate indication settings for running, stopped
// - Configuration never alters the cutoff itself
// - No start until restored and faults reset
// - Start commands ignored while a channel open
// - Reset after restore only if configured
// - Restart needs a fresh start command
// - Single fault cleared by open, reset, close
package torque_cutoff_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_KHZ  = 25000;
  localparam int unsigned FILT_TIME_US  = 1000;
  localparam int unsigned DISC_TIME_MS  = 200;
  localparam int unsigned FILT_CYC      = (FILT_TIME_US * CLK_FREQ_KHZ) / 1000;
  localparam int unsigned DISC_CYC      = DISC_TIME_MS * CLK_FREQ_KHZ;

  // ----------------------------------------------------------------
  // Fault codes and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_NONE     = 16'h0000;
  localparam logic [15:0] CODE_CHAN_A   = 16'hFA81;
  localparam logic [15:0] CODE_CHAN_B   = 16'hFA82;
  localparam logic [15:0] CODE_DUAL_DEF = 16'hF000; // Arbitrary value
  localparam logic        CHAN_RST      = 1'b0;     // Open is the safe reset view

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IND_NONE  = 2'h0,
    IND_EVENT = 2'h1,
    IND_WARN  = 2'h2,
    IND_FAULT = 2'h3
  } ind_sel_e;

  typedef struct packed {
    ind_sel_e run_sel;
    ind_sel_e stop_sel;
  } ind_cfg_s;

  typedef struct packed {
    logic event_p;
    logic warning;
    logic fault;
  } ind_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_CUT  = 3'b100
  } sup_state_e;

endpackage

// ---- verilog/channel_filter.sv ----
// One safety input channel: synchroniser followed by a pulse filter.
// Assumes chan_in is asynchronous; output high means channel energized.
`timescale 1ns/100ps
module channel_filter #(
  parameter int unsigned FILT_CYC = torque_cutoff_pkg::FILT_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic chan_in,
  output logic      chan_q
);

  localparam int CW = $clog2(FILT_CYC + 1);

  logic          sync1_q;
  logic          sync2_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          chan_d;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // Two flops; only the second is read downstream
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= torque_cutoff_pkg::CHAN_RST;
      sync2_q <= torque_cutoff_pkg::CHAN_RST;
    end else begin
      sync1_q <= chan_in;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Pulse filter
  // ----------------------------------------------------------------
  // A new level is adopted only after FILT_CYC+1 steady samples
  always_comb begin
    cnt_d  = '0;
    chan_d = chan_q;
    if (sync2_q != chan_q) begin
      if (cnt_q == CW'(FILT_CYC)) begin
        chan_d = sync2_q;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= '0;
      chan_q <= torque_cutoff_pkg::CHAN_RST;
    end else begin
      cnt_q  <= cnt_d;
      chan_q <= chan_d;
    end
  end

  // Filtered level moves only after a full-length steady difference
  property p_filter_hold;
    @(posedge sys_clk) disable iff (!rstn)
      (chan_q != $past(chan_q)) |-> ($past(cnt_q) == CW'(FILT_CYC));
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("filtered channel changed before filter time");

  // Synchronised level reaches the filter two edges after the pin
  property p_sync_depth;
    @(posedge sys_clk) disable iff (!rstn)
      ##2 (sync2_q == $past(chan_in, 2));
  endproperty
  a_sync_depth: assert property (p_sync_depth)
    else $error("synchroniser depth is not two stages");

endmodule // channel_filter

// ---- test/contact_model.sv ----
// Behavioural model of the two safety contacts feeding the supervisor.
// Assumes the bench calls its tasks; contacts move just after a rising edge.
`timescale 1ns/100ps
module contact_model (
  input  wire logic sys_clk,
  output logic      chan_a_in,
  output logic      chan_b_in
);
  // ------
  // Contacts
  // ------
  // Both contacts start open
  initial begin
    chan_a_in = 1'b0;
    chan_b_in = 1'b0;
  end

  // Move one contact
  task automatic move_one(input int ch, input logic level);
    @(posedge sys_clk);
    if (ch == 0) begin
      chan_a_in <= level;
    end else begin
      chan_b_in <= level;
    end
  endtask

  // Move both, second lags by skew+1 cycles, kept far below the discrepancy time
  task automatic move_pair(input logic level, input int skew);
    move_one(0, level);
    repeat (skew) @(posedge sys_clk);
    move_one(1, level);
  endtask

  // Short dropout on a closed contact
  task automatic bounce(input int ch, input int len);
    move_one(ch, 1'b0);
    repeat (len - 1) @(posedge sys_clk);
    move_one(ch, 1'b1);
  endtask
endmodule // contact_model

// ---- test/testbench.sv ----
// Self-checking bench for the torque cutoff supervisor.
// Assumes short filter and discrepancy counts set through parameters.
`timescale 1ns/100ps
module testbench;
  localparam int FILT = 4;
  localparam int DISC = 20;
  logic                        sys_clk;
  logic                        rstn;
  logic                        start_cmd;
  logic                        reset_cmd;
  torque_cutoff_pkg::ind_cfg_s ind_cfg;
  logic                        gate_enable_q;
  logic                        running_q;
  logic [15:0]                 fault_code_q;
  torque_cutoff_pkg::ind_s     ind_q;
  logic                        chan_a_in;
  logic                        chan_b_in;
  logic                        gate_prev;
  logic [1:0]                  exp_q[$];
  int                          mismatches;
  int                          num_checks;
  int                          ev_n;
  int                          wr_n;
  int                          ft_n;

  torque_cutoff_supervisor #(.FILT_CYC(FILT), .DISC_CYC(DISC)) DUT (
    .sys_clk(sys_clk), .rstn(rstn), .chan_a_in(chan_a_in), .chan_b_in(chan_b_in),
    .start_cmd(start_cmd), .reset_cmd(reset_cmd), .ind_cfg(ind_cfg),
    .gate_enable_q(gate_enable_q), .running_q(running_q),
    .fault_code_q(fault_code_q), .ind_q(ind_q));
  contact_model sw (.sys_clk(sys_clk), .chan_a_in(chan_a_in), .chan_b_in(chan_b_in));

  // ------
  // Clock, checking and monitor
  // ------
  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    num_checks++;
    if (seen !== expd) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Each gate change takes the oldest expected state off the queue; a change with the queue empty counts as a mismatch
  always @(negedge sys_clk) begin
    if (rstn === 1'b1 && gate_enable_q !== gate_prev) begin
      if (exp_q.size() == 0) begin
        check({gate_enable_q, running_q}, {gate_prev, 1'bx});
      end else begin
        check({gate_enable_q, running_q}, exp_q.pop_front());
      end
    end
    gate_prev <= gate_enable_q;
  end

  // Indication counters
  always @(posedge sys_clk) begin
    ev_n <= ev_n + (ind_q.event_p === 1'b1);
    wr_n <= wr_n + (ind_q.warning === 1'b1);
    ft_n <= ft_n + (ind_q.fault === 1'b1);
  end

  // ------
  // Stimulus tasks
  // ------
  task automatic wait_gate(input logic val);
    int n;
    for (n = 0; n < FILT + 10 && gate_enable_q !== val; n++) @(posedge sys_clk);
    if (gate_enable_q !== val) begin
      mismatches++;
      $display("BAD %0t gate wait ran out", $time);
      results();
    end
  endtask

  task automatic start_run();
    exp_q.push_back(2'b11);
    @(posedge sys_clk) start_cmd <= 1'b0;
    @(posedge sys_clk) start_cmd <= 1'b1;
    wait_gate(1'b1);
  endtask

  task automatic stop_run();
    exp_q.push_back(2'b00);
    @(posedge sys_clk) start_cmd <= 1'b0;
    wait_gate(1'b0);
  endtask

  // Fresh start attempt that must be refused
  task automatic try_start();
    @(posedge sys_clk) start_cmd <= 1'b0;
    @(posedge sys_clk) start_cmd <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(gate_enable_q, 1'b0);
  endtask

  task automatic pulse_reset();
    @(posedge sys_clk) reset_cmd <= 1'b1;
    @(posedge sys_clk) reset_cmd <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // Both contacts open while running or stopped, then restore
  task automatic cut(input logic run, input int sel);
    int e0;
    int w0;
    int f0;
    start_run();
    if (!run) stop_run();
    e0 = ev_n;
    w0 = wr_n;
    f0 = ft_n;
    if (run) exp_q.push_back(2'b00);
    sw.move_pair(1'b0, $urandom % 10);
    if (run) wait_gate(1'b0);
    repeat (DISC + 8) @(posedge sys_clk);
    check(ev_n != e0, sel == 1);
    check(wr_n != w0, sel == 2);
    check(ft_n != f0, sel == 3);
    check(fault_code_q, sel == 3 ? torque_cutoff_pkg::CODE_DUAL_DEF
                                 : torque_cutoff_pkg::CODE_NONE);
    try_start();
    sw.move_pair(1'b1, $urandom % 10);
    repeat (FILT + 8) @(posedge sys_clk);
    check(gate_enable_q, 1'b0);
    if (sel == 3) begin
      try_start();
      pulse_reset();
      check(fault_code_q, torque_cutoff_pkg::CODE_NONE);
    end
    start_run();
    stop_run();
  endtask

  // Single contact loss and the clearing walk
  task automatic single(input int ch);
    start_run();
    exp_q.push_back(2'b00);
    sw.move_one(ch, 1'b0);
    wait_gate(1'b0);
    repeat (DISC + 8) @(posedge sys_clk);
    check(fault_code_q, ch == 0 ? 16'hFA81 : 16'hFA82);
    check(ind_q.fault, 1'b1);
    try_start();
    pulse_reset();
    check(fault_code_q, ch == 0 ? 16'hFA81 : 16'hFA82);
    sw.move_one(1 - ch, 1'b0);
    repeat (FILT + 8) @(posedge sys_clk);
    pulse_reset();
    check(fault_code_q, torque_cutoff_pkg::CODE_NONE);
    sw.move_pair(1'b1, 0);
    repeat (FILT + 8) @(posedge sys_clk);
    pulse_reset();
    start_run();
    stop_run();
  endtask

  // ------
  // Main sequence
  // ------
  initial begin
    int i;
    void'($urandom(83560));
    rstn = 1'b0;
    start_cmd = 1'b1;
    reset_cmd = 1'b0;
    ind_cfg = '0;
    gate_prev = 1'b0;
    mismatches = 0;
    num_checks = 0;
    ev_n = 0;
    wr_n = 0;
    ft_n = 0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    sw.move_pair(1'b1, 0);
    repeat (FILT + 8) @(posedge sys_clk);
    check(gate_enable_q, 1'b0);
    start_run();
    for (i = 0; i < 8; i++) begin
      sw.bounce(i % 2, 1 + $urandom % FILT);
      repeat (FILT + 6) @(posedge sys_clk);
    end
    check(gate_enable_q, 1'b1);
    stop_run();
    for (i = 0; i < 4; i++) begin
      @(posedge sys_clk) ind_cfg <= {2'(i), 2'(3 - i)};
      cut(1'b1, i);
      cut(1'b0, 3 - i);
    end
    @(posedge sys_clk) ind_cfg <= '0;
    single(0);
    single(1);
    results();
  end
endmodule // testbench
